/* dv/cpu_addressing_mode_unit_tb_top.sv */
// self-checking bench for the operand addressing unit
// assumes the same-cycle memory model and a 25 MHz core clock
`timescale 1ns/100ps
module cpu_addressing_mode_unit_tb_top;
  typedef am_pkg::mode_t m_t;
  // per-mode masks, bit n stands for mode value n
  localparam logic [16:0] ZERO_OP = 17'h00011;
  localparam logic [16:0] TWO_OP  = 17'h18048;
  localparam logic [16:0] PTR2    = 17'h00500;
  localparam logic [16:0] PTR1    = 17'h15280;
  localparam logic [16:0] LONG    = 17'h00548;
  localparam logic [16:0] SEC90   = 17'h0007F;
  localparam logic [16:0] NOEA    = 17'h01803;
  logic        clk_sys, rst_n, start, mem_only, mem_rd;
  logic        busy, done, illegal, use_second;
  m_t          base_mode, eff_mode;
  logic [7:0]  prefix, index_first, index_second, mem_rdata, imm_data;
  logic [15:0] pc, mem_addr, ea, branch_target, next_pc;
  logic [2:0]  instr_len;
  int          fails, checks_done, cyc;
  logic [7:0]  pfx [4] = '{8'h00, 8'h90, 8'h91, 8'h92};

  always #20 clk_sys = ~clk_sys;

  cpu_addressing_mode_unit i_dut
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .start(start),
    .base_mode(base_mode), .prefix(prefix), .mem_only(mem_only),
    .pc(pc), .index_first(index_first), .index_second(index_second),
    .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .busy(busy), .done(done), .eff_mode(eff_mode), .ea(ea),
    .branch_target(branch_target), .next_pc(next_pc),
    .imm_data(imm_data), .instr_len(instr_len), .illegal(illegal),
    .use_second(use_second)
  );

  mem_model i_mem
  (
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata)
  );

  task automatic cmp(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [7:0] rb(input bit cor);
    rb = cor ? 8'hFF : 8'($urandom);
  endfunction

  // mode after the prefix byte, worked out independently
  function automatic m_t conv(input m_t m, input logic [7:0] p);
    conv = m;
    if (p == 8'h91 || p == 8'h92)
      case (m)
        am_pkg::M_IDX_S: conv = am_pkg::M_IIDX_S;
        am_pkg::M_IDX_L: conv = am_pkg::M_IIDX_L;
        default: ;
      endcase
    if (p == 8'h92)
      case (m)
        am_pkg::M_DIR_S:  conv = am_pkg::M_IND_S;
        am_pkg::M_DIR_L:  conv = am_pkg::M_IND_L;
        am_pkg::M_REL_D:  conv = am_pkg::M_REL_I;
        am_pkg::M_BIT_D:  conv = am_pkg::M_BIT_I;
        am_pkg::M_BREL_D: conv = am_pkg::M_BREL_I;
        default: ;
      endcase
  endfunction

  // one instruction; poke retriggers start and moves pc while busy
  task automatic run(input m_t m, input logic [7:0] p, input bit cor,
                     input bit poke);
    logic [15:0] a, e, np;
    logic [7:0]  ix, iy, b0, b1, p0, p1, idx, off;
    m_t          em;
    bit          mo, sec, pf;
    int          n, rds, oc, pt;
    a = {8'($urandom_range(254, 1)), 8'($urandom)};
    ix = rb(cor);
    iy = rb(cor);
    mo = 1'($urandom);
    i_mem.mem[a] = rb(cor);
    i_mem.mem[a + 16'h0001] = rb(cor);
    b0 = i_mem.mem[a];
    b1 = i_mem.mem[a + 16'h0001];
    i_mem.mem[{8'h00, b0}] = rb(cor);
    i_mem.mem[{8'h00, b0 + 8'h01}] = rb(cor);
    p0 = i_mem.mem[{8'h00, b0}];
    p1 = i_mem.mem[{8'h00, b0 + 8'h01}];
    em = conv(m, p);
    pf = (p == 8'h90) || (p == 8'h91) || (p == 8'h92);
    sec = (p == 8'h91) || (p == 8'h90 && SEC90[em]);
    idx = sec ? iy : ix;
    oc = ZERO_OP[em] ? 0 : (TWO_OP[em] ? 2 : 1);
    pt = PTR2[em] ? 2 : (PTR1[em] ? 1 : 0);
    np = a + 16'(oc);
    case (em)
      am_pkg::M_DIR_L:  e = {b0, b1};
      am_pkg::M_IDX0:   e = {8'h00, idx};
      am_pkg::M_IDX_S:  e = {8'h00, b0} + idx;
      am_pkg::M_IDX_L:  e = {b0, b1} + idx;
      am_pkg::M_IND_L:  e = {p0, p1};
      am_pkg::M_IIDX_S: e = {8'h00, p0} + idx;
      am_pkg::M_IIDX_L: e = {p0, p1} + idx;
      am_pkg::M_IND_S, am_pkg::M_BIT_I, am_pkg::M_BREL_I:
        e = {8'h00, p0};
      default: e = NOEA[em] ? 16'h0000 : {8'h00, b0};
    endcase
    off = (em == am_pkg::M_REL_D) ? b0 : (em == am_pkg::M_REL_I) ? p0 :
          (em == am_pkg::M_BREL_D || em == am_pkg::M_BREL_I) ? b1 : 8'h00;
    @(posedge clk_sys);
    start <= 1'b1;
    base_mode <= m;
    prefix <= p;
    mem_only <= mo;
    pc <= a;
    index_first <= ix;
    index_second <= iy;
    @(posedge clk_sys);
    start <= 1'b0;
    #1;
    n = 0;
    rds = 0;
    // bounded wait; a stray start or pc change must be ignored
    while (done !== 1'b1 && n < 12)
    begin
      @(posedge clk_sys);
      n++;
      start <= poke && n == 1;
      if (poke && n == 1)
        pc <= ~a;
      #1;
      if (mem_rd === 1'b1)
        rds++;
    end
    // a one-cycle instruction leaves the loop with the poke still up
    start <= 1'b0;
    cmp("latency", 16'(1 + 2 * oc + 2 * pt), 16'(n));
    cmp("reads", 16'(oc + pt), 16'(rds));
    cmp("eff_mode", 16'(em), 16'(eff_mode));
    cmp("use_second", 16'(sec), 16'(use_second));
    cmp("ea", e, ea);
    cmp("next_pc", np, next_pc);
    cmp("instr_len", 16'(1 + pf + oc), 16'(instr_len));
    cmp("branch", np + {{8{off[7]}}, off}, branch_target);
    cmp("illegal", 16'(mo && LONG[em]), 16'(illegal));
    if (oc != 0)
      cmp("imm_data", 16'(b0), 16'(imm_data));
    if (poke)
    begin
      @(posedge clk_sys);
      #1;
      cmp("refused", 16'h0000, 16'(busy));
    end
  endtask

  // reset in mid-operation clears busy, mem_rd, done and ea
  task automatic reset_mid();
    @(posedge clk_sys);
    start <= 1'b1;
    base_mode <= am_pkg::M_BREL_I;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    cmp("rst_busy", 16'h0000, 16'(busy));
    cmp("rst_rd", 16'h0000, 16'(mem_rd));
    @(posedge clk_sys);
    #1;
    cmp("rst_done", 16'h0000, 16'(done));
    cmp("rst_ea", 16'h0000, ea);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, well above the nearly two thousand cycles needed
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      fails++;
      results();
    end
  end

  initial
  begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    start = 1'b0;
    mem_only = 1'b0;
    base_mode = am_pkg::M_INH;
    prefix = 8'h00;
    pc = 16'h0000;
    index_first = 8'h00;
    index_second = 8'h00;
    void'($urandom(18));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    // every mode with every prefix, random then all-ones bytes
    for (int c = 0; c < 2; c++)
      for (int m = 0; m < 17; m++)
        for (int k = 0; k < 4; k++)
          run(m_t'(m), pfx[k], c[0], 1'b0);
    $display("test mode and prefix sweep done");
    for (int i = 0; i < 150; i++)
      run(m_t'($urandom_range(16, 0)), ($urandom_range(4, 0) == 4) ?
          8'($urandom) : pfx[$urandom_range(3, 0)], 1'b0, i % 5 == 0);
    $display("test random instructions done");
    reset_mid();
    run(am_pkg::M_IND_L, 8'h00, 1'b0, 1'b0);
    $display("test reset in mid-run done");
    results();
  end
endmodule

/* dv/mem_model.sv */
// behavioural program and data memory beside the addressing unit
// assumes the sequencer captures data in the cycle its strobe stands
`timescale 1ns/100ps
module mem_model
(
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [0:65535];

  // data stands while the registered strobe stands; the inverse
  // otherwise, so a capture outside the strobe never looks valid
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
endmodule

/* rtl/am_pkg.sv */
// addressing-mode constants, mode enumeration and decode functions
// assumes one cpu clock; shared by the sequencer and the testbench
package am_pkg;

  localparam logic [7:0] PFX_NONE     = 8'h00;
  localparam logic [7:0] PFX_SECOND   = 8'h90;
  localparam logic [7:0] PFX_IND_SEC  = 8'h91;
  localparam logic [7:0] PFX_INDIRECT = 8'h92;
  localparam logic [7:0] PAGE_ZERO    = 8'h00;
  localparam logic [15:0] SHORT_MAX   = 16'h01FE;
  localparam logic [2:0] OPCODE_LEN   = 3'h1;

  // seventeen modes
  typedef enum logic [4:0] {
    M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX0, M_IDX_S, M_IDX_L,
    M_IND_S, M_IND_L, M_IIDX_S, M_IIDX_L, M_REL_D, M_REL_I,
    M_BIT_D, M_BIT_I, M_BREL_D, M_BREL_I
  } mode_t;

  typedef enum logic [2:0] {
    S_IDLE, S_OPND_REQ, S_OPND_CAP, S_PTR_REQ, S_PTR_CAP, S_CALC
  } seq_state_t;

  function automatic logic is_prefix(input logic [7:0] p);
    is_prefix = (p == PFX_SECOND) || (p == PFX_IND_SEC) ||
                (p == PFX_INDIRECT);
  endfunction

  // mode after prefix conversion
  function automatic mode_t apply_prefix(input mode_t m,
                                         input logic [7:0] p);
    apply_prefix = m;
    if (p == PFX_INDIRECT || p == PFX_IND_SEC)
    begin
      case (m)
        M_IDX_S:  apply_prefix = M_IIDX_S;
        M_IDX_L:  apply_prefix = M_IIDX_L;
        default:  apply_prefix = m;
      endcase
    end
    if (p == PFX_INDIRECT)
    begin
      case (m)
        M_DIR_S:  apply_prefix = M_IND_S;
        M_DIR_L:  apply_prefix = M_IND_L;
        M_REL_D:  apply_prefix = M_REL_I;
        M_BIT_D:  apply_prefix = M_BIT_I;
        M_BREL_D: apply_prefix = M_BREL_I;
        default:  ;
      endcase
    end
  endfunction

  // bytes following the opcode
  function automatic logic [1:0] opnd_count(input mode_t m);
    case (m)
      M_INH, M_IDX0:               opnd_count = 2'h0;
      M_DIR_L, M_IDX_L,
      M_BREL_D, M_BREL_I:          opnd_count = 2'h2;
      default:                     opnd_count = 2'h1;
    endcase
  endfunction

  // pointer bytes fetched from page zero
  function automatic logic [1:0] ptr_count(input mode_t m);
    case (m)
      M_IND_L, M_IIDX_L:           ptr_count = 2'h2;
      M_IND_S, M_IIDX_S, M_REL_I,
      M_BIT_I, M_BREL_I:           ptr_count = 2'h1;
      default:                     ptr_count = 2'h0;
    endcase
  endfunction

  function automatic logic is_long(input mode_t m);
    is_long = (m == M_DIR_L) || (m == M_IDX_L) ||
              (m == M_IND_L) || (m == M_IIDX_L);
  endfunction

endpackage

/* rtl/cpu_addressing_mode_unit.sv */
// operand fetch and effective-address sequencer for the cpu core
// assumes memory data is valid while mem_rd stands, and that
// pc points at the byte after the opcode when start is pulsed
`timescale 1ns/100ps
module cpu_addressing_mode_unit
(
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          start,
  input  wire am_pkg::mode_t base_mode,
  input  wire logic [7:0]    prefix,
  input  wire logic          mem_only,
  input  wire logic [15:0]   pc,
  input  wire logic [7:0]    index_first,
  input  wire logic [7:0]    index_second,
  input  wire logic [7:0]    mem_rdata,
  output logic               mem_rd,
  output logic      [15:0]   mem_addr,
  output logic               busy,
  output logic               done,
  output am_pkg::mode_t      eff_mode,
  output logic      [15:0]   ea,
  output logic      [15:0]   branch_target,
  output logic      [15:0]   next_pc,
  output logic      [7:0]    imm_data,
  output logic      [2:0]    instr_len,
  output logic               illegal,
  output logic               use_second
);

  typedef struct packed {
    am_pkg::seq_state_t state;
    am_pkg::mode_t      mode;
    logic               use_y;
    logic [7:0]         idx;
    logic [15:0]        pc;
    logic [1:0]         nop;
    logic [1:0]         npt;
    logic [1:0]         cnt;
    logic [7:0]         b0;
    logic [7:0]         b1;
    logic [15:0]        ptr;
    logic               rd;
    logic [15:0]        addr;
    logic               busy;
    logic               done;
    logic [15:0]        ea;
    logic [15:0]        target;
    logic [15:0]        npc;
    logic [2:0]         len;
    logic               illegal;
  } am_state_t;

  am_state_t          s;
  am_state_t          next_s;
  am_pkg::mode_t      pm;
  logic [15:0]        add_base;
  logic               add_short;
  logic [15:0]        add_sum;
  logic [7:0]         rel_ofs;
  logic [15:0]        end_pc;

  ea_adder u_adder
  (
    .base      (add_base),
    .index     (s.idx),
    .short_sum (add_short),
    .sum       (add_sum)
  );

  // adder operand and relative offset selection per mode
  always_comb
  begin
    add_base  = 16'h0000;
    add_short = 1'b1;
    rel_ofs   = 8'h00;
    case (s.mode)
      am_pkg::M_IDX_S:  add_base = {8'h00, s.b0};
      am_pkg::M_IDX_L:
      begin
        add_base  = {s.b0, s.b1};
        add_short = 1'b0;
      end
      am_pkg::M_IIDX_S: add_base = {8'h00, s.ptr[7:0]};
      am_pkg::M_IIDX_L:
      begin
        add_base  = s.ptr;
        add_short = 1'b0;
      end
      am_pkg::M_REL_D:  rel_ofs = s.b0;
      am_pkg::M_REL_I:  rel_ofs = s.ptr[7:0];
      am_pkg::M_BREL_D, am_pkg::M_BREL_I: rel_ofs = s.b1;
      default:          ;
    endcase
  end

  assign pm     = am_pkg::apply_prefix(base_mode, prefix);
  assign end_pc = s.pc + {14'h0000, s.nop};

  // sequencer: operand bytes, then pointer bytes, then address
  always_comb
  begin
    next_s      = s;
    next_s.rd   = 1'b0;
    next_s.done = 1'b0;
    case (s.state)
      am_pkg::S_IDLE:
      if (start)
      begin
        next_s.mode  = pm;
        // 90 swaps index only for plain modes; 91 always
        next_s.use_y = (prefix == am_pkg::PFX_IND_SEC) ||
                       (prefix == am_pkg::PFX_SECOND &&
                        (pm == am_pkg::M_INH || pm == am_pkg::M_IMM ||
                         pm == am_pkg::M_DIR_S || pm == am_pkg::M_DIR_L ||
                         pm == am_pkg::M_IDX0 || pm == am_pkg::M_IDX_S ||
                         pm == am_pkg::M_IDX_L));
        // index follows the selection, so 90 leaves indirect modes on x
        next_s.idx   = next_s.use_y ? index_second : index_first;
        next_s.pc    = pc;
        next_s.nop   = am_pkg::opnd_count(pm);
        next_s.npt   = am_pkg::ptr_count(pm);
        next_s.cnt   = 2'h0;
        next_s.b0    = 8'h00;
        next_s.b1    = 8'h00;
        next_s.ptr   = 16'h0000;
        next_s.len   = am_pkg::OPCODE_LEN +
                       {2'h0, am_pkg::is_prefix(prefix)} +
                       {1'b0, am_pkg::opnd_count(pm)};
        next_s.illegal = mem_only && am_pkg::is_long(pm);
        next_s.busy  = 1'b1;
        next_s.state = (am_pkg::opnd_count(pm) != 2'h0) ?
                       am_pkg::S_OPND_REQ : am_pkg::S_CALC;
      end
      am_pkg::S_OPND_REQ:
      begin
        next_s.rd    = 1'b1;
        next_s.addr  = s.pc + {14'h0000, s.cnt};
        next_s.state = am_pkg::S_OPND_CAP;
      end
      am_pkg::S_OPND_CAP:
      begin
        // first byte is the high byte of a word operand
        if (s.cnt == 2'h0)
          next_s.b0 = mem_rdata;
        else
          next_s.b1 = mem_rdata;
        next_s.cnt = s.cnt + 2'h1;
        if (s.cnt + 2'h1 < s.nop)
          next_s.state = am_pkg::S_OPND_REQ;
        else if (s.npt != 2'h0)
        begin
          next_s.cnt   = 2'h0;
          next_s.state = am_pkg::S_PTR_REQ;
        end
        else
          next_s.state = am_pkg::S_CALC;
      end
      am_pkg::S_PTR_REQ:
      begin
        // pointer byte address wraps inside page zero on purpose
        next_s.rd    = 1'b1;
        next_s.addr  = {am_pkg::PAGE_ZERO,
                        s.b0 + {6'h00, s.cnt}};
        next_s.state = am_pkg::S_PTR_CAP;
      end
      am_pkg::S_PTR_CAP:
      begin
        next_s.ptr = {s.ptr[7:0], mem_rdata};
        next_s.cnt = s.cnt + 2'h1;
        next_s.state = (s.cnt + 2'h1 < s.npt) ?
                       am_pkg::S_PTR_REQ : am_pkg::S_CALC;
      end
      am_pkg::S_CALC:
      begin
        next_s.npc    = end_pc;
        next_s.target = end_pc + {{8{rel_ofs[7]}}, rel_ofs};
        case (s.mode)
          am_pkg::M_DIR_S, am_pkg::M_BIT_D, am_pkg::M_BREL_D:
            next_s.ea = {am_pkg::PAGE_ZERO, s.b0};
          am_pkg::M_DIR_L:
            next_s.ea = {s.b0, s.b1};
          am_pkg::M_IDX0:
            next_s.ea = {am_pkg::PAGE_ZERO, s.idx};
          am_pkg::M_IDX_S, am_pkg::M_IDX_L,
          am_pkg::M_IIDX_S, am_pkg::M_IIDX_L:
            next_s.ea = add_sum;
          am_pkg::M_IND_S, am_pkg::M_BIT_I, am_pkg::M_BREL_I:
            next_s.ea = {am_pkg::PAGE_ZERO, s.ptr[7:0]};
          am_pkg::M_IND_L:
            next_s.ea = s.ptr;
          default:
            next_s.ea = 16'h0000;
        endcase
        next_s.done  = 1'b1;
        next_s.busy  = 1'b0;
        next_s.state = am_pkg::S_IDLE;
      end
      default:
        next_s.state = am_pkg::S_IDLE;
    endcase
  end

  // single state register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign mem_rd        = s.rd;
  assign mem_addr      = s.addr;
  assign busy          = s.busy;
  assign done          = s.done;
  assign eff_mode      = s.mode;
  assign ea            = s.ea;
  assign branch_target = s.target;
  assign next_pc       = s.npc;
  assign imm_data      = s.b0;
  assign instr_len     = s.len;
  assign illegal       = s.illegal;
  assign use_second    = s.use_y;

  chk_len_inherent: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done && eff_mode == am_pkg::M_INH |-> next_pc == s.pc)
    else $error("inherent mode consumed operand bytes");
  chk_len_formula: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done |-> instr_len == am_pkg::OPCODE_LEN + {1'b0, s.nop} +
             {2'h0, s.len > ({1'b0, s.nop} + 3'h1)})
    else $error("instruction length mismatch");
  chk_imm_one_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    start && !busy && pm == am_pkg::M_IMM |=> ##1 mem_rd ##1 !mem_rd
    ##1 done)
    else $error("immediate fetch timing wrong");
  chk_short_page: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done && (eff_mode == am_pkg::M_DIR_S || eff_mode == am_pkg::M_IND_S ||
             eff_mode == am_pkg::M_BIT_D || eff_mode == am_pkg::M_BIT_I)
    |-> ea[15:8] == 8'h00)
    else $error("short mode left page zero");
  chk_short_index: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done && (eff_mode == am_pkg::M_IDX_S || eff_mode == am_pkg::M_IIDX_S)
    |-> ea <= am_pkg::SHORT_MAX)
    else $error("short indexed sum wrapped or overflowed");
  chk_no_offset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done && eff_mode == am_pkg::M_IDX0 |-> ea == {8'h00, s.idx})
    else $error("no-offset indexed address wrong");
  chk_ptr_page: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(s.state) == am_pkg::S_PTR_REQ && mem_rd |-> mem_addr[15:8] ==
    8'h00)
    else $error("pointer read outside page zero");
  chk_rel_target: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done && eff_mode == am_pkg::M_REL_D |->
    branch_target == next_pc + {{8{s.b0[7]}}, s.b0})
    else $error("relative target wrong");
  chk_second_idx: assert property (@(posedge clk_sys) disable iff (!rst_n)
    start && !busy && prefix == am_pkg::PFX_SECOND &&
    base_mode == am_pkg::M_IDX0 |=> ##1 done && ea ==
    {8'h00, $past(index_second, 2)})
    else $error("second index prefix ignored");
  chk_ind_convert: assert property (@(posedge clk_sys) disable iff (!rst_n)
    start && !busy && prefix == am_pkg::PFX_INDIRECT &&
    base_mode == am_pkg::M_DIR_S |=> eff_mode == am_pkg::M_IND_S)
    else $error("indirect prefix did not convert mode");
  chk_mem_short: assert property (@(posedge clk_sys) disable iff (!rst_n)
    start && !busy && mem_only && pm == am_pkg::M_DIR_L |=> illegal)
    else $error("long mode allowed for memory operation");

endmodule

/* rtl/ea_adder.sv */
// unsigned index adder for effective addresses
// assumes base and index are stable while the sequencer calculates
`timescale 1ns/100ps
module ea_adder
(
  input  wire logic [15:0] base,
  input  wire logic [7:0]  index,
  input  wire logic        short_sum,
  output logic      [15:0] sum
);

  logic [8:0] short_part;

  // short form keeps the ninth bit, so no wrap past FF
  assign short_part = {1'b0, base[7:0]} + {1'b0, index};
  assign sum = short_sum ? {7'h00, short_part}
                         : base + {8'h00, index};

endmodule
